// [rtl/dcsb_pkg.sv]
package dcsb_pkg;

	// Sizes
	localparam int NCH    = 6;
	localparam int NLVL   = 4;
	localparam int IDW    = 5;
	localparam int CNTW   = 16;
	localparam int AW     = 8;
	localparam int NIRQ   = 3;

	// Register offsets
	localparam logic [7:0] OFF_BUSY   = 8'h28;
	localparam logic [7:0] OFF_PEND   = 8'h2c;
	localparam logic [7:0] OFF_ACTIVE = 8'h30;
	localparam logic [7:0] OFF_DBASE  = 8'h34;
	localparam logic [7:0] OFF_WBASE  = 8'h38;
	localparam logic [7:0] OFF_ISTAT  = 8'h60;
	localparam logic [7:0] OFF_IMASK  = 8'h64;

	// Field positions of the active channel register
	localparam int ACT_CNT_LSB   = 16;
	localparam int ACT_BUSY_BIT  = 15;
	localparam int ACT_ID_LSB    = 8;
	localparam int ACT_LVL_LSB   = 0;

	// Interrupt status bits
	localparam int IRQ_BUS_ERR   = 0;
	localparam int IRQ_TRIG_DONE = 1;
	localparam int IRQ_SLOT_DONE = 2;

	// Bytes per channel slot, as a shift
	localparam int SLOT_SHIFT    = 4;

	// Reset values
	localparam logic [31:0] BASE_RST = 32'h0000_0000;

	typedef struct packed {
		logic [NCH-1:0]   start;
		logic [NCH-1:0]   trig_done;
		logic [NCH-1:0]   bus_err;
		logic [NCH-1:0]   enabled;
		logic [NCH-1:0]   request;
		logic [NCH-1:0]   exec_start;
		logic [2*NCH-1:0] level;
	} dcsb_chan_evt_t;

	typedef struct packed {
		logic           valid;
		logic [IDW-1:0] channel;
	} dcsb_grant_t;

	typedef struct packed {
		logic            req;
		logic            we;
		logic [31:0]     addr;
		logic [CNTW-1:0] wdata;
	} dcsb_mem_req_t;

	typedef struct packed {
		logic            ack;
		logic [CNTW-1:0] rdata;
	} dcsb_mem_rsp_t;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [31:0]   wdata;
		logic          wr;
		logic          rd;
	} dcsb_bus_req_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WRITE = 3'b010,
		ST_FETCH = 3'b100
	} dcsb_phase_t;

	typedef struct packed {
		dcsb_phase_t     st;
		logic [NCH-1:0]  busy;
		logic [NCH-1:0]  pend;
		logic [NLVL-1:0] priority_level_executing;
		logic [CNTW-1:0] count;
		logic            active_slot_occupied;
		logic [IDW-1:0]  id;
		logic [IDW-1:0]  old_id;
		logic [31:0]     desc_base;
		logic [31:0]     wrb_base;
		logic [NIRQ-1:0] istat;
		logic [NIRQ-1:0] imask;
		logic            irq;
		logic [31:0]     rdata;
		dcsb_mem_req_t   mem;
		logic [31:0]     desc_slot;
		logic            grant_ready;
	} dcsb_state_t;

	localparam dcsb_state_t STATE_RST = '{
		st:          ST_IDLE,
		desc_base:   BASE_RST,
		wrb_base:    BASE_RST,
		grant_ready: 1'b1,
		default:     '0
	};

endpackage

// [rtl/dcsb_top.sv]
`timescale 1ns/1ps
// Function
// - A channel's busy bit clears on trigger action done, bus error or disable.
// - A channel's busy bit sets when that channel starts a transfer.
// - A channel's pending bit clears on trigger execution start, bus error or disable.
// - A channel's pending bit sets while a transfer waits, one bit per channel for six.
// - The active register shows the sixteen-bit block count in bits 31:16.
// - On a new grant the old active count is written back to its write-back slot.
// - The active count is meaningful only while the active busy flag is set.
// - The active busy flag, bit 15, clears once the count is written back.
// - The active busy flag sets when the next count is read from the write-back slot.
// - The five-bit active channel field follows each grant taken while grant_ready is high; grants during a swap are ignored.
// - Each of four level flags is set while a request at that level runs or waits.
// - Reserved bits read as zero and are written as zero.
// - The write-back base at 0x38 is a 32-bit read-write register reset to zero.

module dcsb_top (
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire dcsb_pkg::dcsb_bus_req_t bus,
	output logic [31:0]                 rdata,
	input  wire dcsb_pkg::dcsb_chan_evt_t evt,
	input  wire dcsb_pkg::dcsb_grant_t  grant,
	input  wire logic                   beat_done,
	output logic                        grant_ready,
	output dcsb_pkg::dcsb_mem_req_t     mem_req,
	input  wire dcsb_pkg::dcsb_mem_rsp_t mem_rsp,
	output logic [31:0]                 desc_slot_addr,
	output logic [dcsb_pkg::NCH-1:0]    channel_activity_flags,
	output logic [dcsb_pkg::NCH-1:0]    pending_channel_flags,
	output logic                        irq
);

	////////////////////////////////////////////////////////////////////////
	// Slot address of a channel within a memory section
	function automatic logic [31:0] slot_addr(
		input logic [31:0]              base,
		input logic [dcsb_pkg::IDW-1:0] idx
	);
		logic [31:0] off;
		off = 32'(idx) << dcsb_pkg::SLOT_SHIFT;
		slot_addr = base + off;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State
	dcsb_pkg::dcsb_state_t s;
	dcsb_pkg::dcsb_state_t next_s;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [dcsb_pkg::NIRQ-1:0] ev;
		logic [dcsb_pkg::NIRQ-1:0] clr;
		logic [1:0]                lv;
		logic                      swap_done;
		ev        = '0;
		clr       = '0;
		lv        = '0;
		swap_done = 1'b0;
		next_s    = s;

		// Per-channel busy and pending, setting wins over clearing
		for (int i = 0; i < dcsb_pkg::NCH; i++) begin
			if (evt.trig_done[i] || evt.bus_err[i] || !evt.enabled[i]) begin
				next_s.busy[i] = 1'b0;
			end
			if (evt.start[i]) begin
				next_s.busy[i] = 1'b1;
			end
			if (evt.exec_start[i] || evt.bus_err[i] || !evt.enabled[i]) begin
				next_s.pend[i] = 1'b0;
			end
			if (evt.request[i]) begin
				next_s.pend[i] = 1'b1;
			end
		end

		// Level flags from running or waiting channels
		next_s.priority_level_executing = '0;
		for (int i = 0; i < dcsb_pkg::NCH; i++) begin
			lv = evt.level[2*i +: 2];
			if (s.busy[i] || s.pend[i]) begin
				next_s.priority_level_executing[lv] = 1'b1;
			end
		end

		// Beat countdown of the active slot
		if (s.st == dcsb_pkg::ST_IDLE && s.active_slot_occupied && beat_done
			&& s.count != '0) begin
			next_s.count = s.count - 16'h0001;
		end

		// Slot swap sequence
		unique case (s.st)
			dcsb_pkg::ST_IDLE: begin
				if (grant.valid) begin
					next_s.old_id    = s.id;
					next_s.id        = grant.channel;
					next_s.desc_slot = slot_addr(s.desc_base, grant.channel);
					next_s.mem.req   = 1'b1;
					if (s.active_slot_occupied) begin
						next_s.st        = dcsb_pkg::ST_WRITE;
						next_s.mem.we    = 1'b1;
						next_s.mem.addr  = slot_addr(s.wrb_base, s.id);
						next_s.mem.wdata = s.count;
					end else begin
						next_s.st        = dcsb_pkg::ST_FETCH;
						next_s.mem.we    = 1'b0;
						next_s.mem.addr  = slot_addr(s.wrb_base, grant.channel);
						next_s.mem.wdata = '0;
					end
				end
			end
			dcsb_pkg::ST_WRITE: begin
				if (mem_rsp.ack) begin
					next_s.active_slot_occupied = 1'b0;
					next_s.st        = dcsb_pkg::ST_FETCH;
					next_s.mem.req   = 1'b1;
					next_s.mem.we    = 1'b0;
					next_s.mem.addr  = slot_addr(s.wrb_base, s.id);
					next_s.mem.wdata = '0;
				end
			end
			dcsb_pkg::ST_FETCH: begin
				if (mem_rsp.ack) begin
					next_s.active_slot_occupied = 1'b1;
					next_s.count   = mem_rsp.rdata;
					next_s.st      = dcsb_pkg::ST_IDLE;
					next_s.mem.req = 1'b0;
					swap_done      = 1'b1;
				end
			end
		endcase
		next_s.grant_ready = (next_s.st == dcsb_pkg::ST_IDLE);

		// Software writes
		if (bus.wr) begin
			unique case (bus.addr)
				dcsb_pkg::OFF_DBASE: next_s.desc_base = bus.wdata;
				dcsb_pkg::OFF_WBASE: next_s.wrb_base = bus.wdata;
				dcsb_pkg::OFF_ISTAT: clr = bus.wdata[dcsb_pkg::NIRQ-1:0];
				dcsb_pkg::OFF_IMASK: begin
					next_s.imask = bus.wdata[dcsb_pkg::NIRQ-1:0];
				end
				default: ;
			endcase
		end

		// Sticky interrupt status, event wins over write-one-to-clear
		ev[dcsb_pkg::IRQ_BUS_ERR]   = |evt.bus_err;
		ev[dcsb_pkg::IRQ_TRIG_DONE] = |evt.trig_done;
		ev[dcsb_pkg::IRQ_SLOT_DONE] = swap_done;
		next_s.istat = (s.istat & ~clr) | ev;
		next_s.irq   = |(next_s.istat & next_s.imask);

		// Read data, valid the cycle after the strobe only
		next_s.rdata = '0;
		if (bus.rd) begin
			unique case (bus.addr)
				dcsb_pkg::OFF_BUSY: next_s.rdata = 32'(s.busy);
				dcsb_pkg::OFF_PEND: next_s.rdata = 32'(s.pend);
				dcsb_pkg::OFF_ACTIVE: begin
					next_s.rdata[dcsb_pkg::ACT_CNT_LSB +: dcsb_pkg::CNTW]
						= s.count;
					next_s.rdata[dcsb_pkg::ACT_BUSY_BIT]
						= s.active_slot_occupied;
					next_s.rdata[dcsb_pkg::ACT_ID_LSB +: dcsb_pkg::IDW] = s.id;
					next_s.rdata[dcsb_pkg::ACT_LVL_LSB +: dcsb_pkg::NLVL]
						= s.priority_level_executing;
				end
				dcsb_pkg::OFF_DBASE: next_s.rdata = s.desc_base;
				dcsb_pkg::OFF_WBASE: next_s.rdata = s.wrb_base;
				dcsb_pkg::OFF_ISTAT: next_s.rdata = 32'(s.istat);
				dcsb_pkg::OFF_IMASK: next_s.rdata = 32'(s.imask);
				default: next_s.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register the state
	always_ff @(posedge clock) begin
		if (!rstn) begin
			s <= dcsb_pkg::STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state
	assign rdata                  = s.rdata;
	assign grant_ready            = s.grant_ready;
	assign mem_req                = s.mem;
	assign desc_slot_addr         = s.desc_slot;
	assign channel_activity_flags = s.busy;
	assign pending_channel_flags  = s.pend;
	assign irq                    = s.irq;

endmodule

// [tb/dcsb_top_sva.sv]
`timescale 1ns/1ps
// Flag and slot swap checks at the top ports
module dcsb_top_sva (
	input wire logic                     clock,
	input wire logic                     rstn,
	input wire dcsb_pkg::dcsb_bus_req_t  bus,
	input wire logic [31:0]              rdata,
	input wire dcsb_pkg::dcsb_chan_evt_t evt,
	input wire dcsb_pkg::dcsb_grant_t    grant,
	input wire logic                     grant_ready,
	input wire dcsb_pkg::dcsb_mem_req_t  mem_req,
	input wire dcsb_pkg::dcsb_mem_rsp_t  mem_rsp,
	input wire logic [5:0]               channel_activity_flags,
	input wire logic [5:0]               pending_channel_flags
);
	logic [5:0] bclr;
	logic [5:0] pclr;
	// Clear causes that no set event overrides
	assign bclr = (evt.trig_done | evt.bus_err | ~evt.enabled) & ~evt.start;
	assign pclr = (evt.exec_start | evt.bus_err | ~evt.enabled) & ~evt.request;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////
	busy_set_a: assert property (|evt.start |=>
		&(channel_activity_flags | ~$past(evt.start))) else $error("busy set");
	busy_clr_a: assert property (|bclr |=>
		!(|(channel_activity_flags & $past(bclr)))) else $error("busy clear");
	pend_set_a: assert property (|evt.request |=>
		&(pending_channel_flags | ~$past(evt.request))) else $error("pend set");
	pend_clr_a: assert property (|pclr |=>
		!(|(pending_channel_flags & $past(pclr)))) else $error("pend clear");
	busy_read_a: assert property (bus.rd && bus.addr == 8'h28 |=>
		rdata == {26'h0, $past(channel_activity_flags)}) else $error("busy rd");
	grant_take_a: assert property (grant.valid && grant_ready |=>
		mem_req.req && !grant_ready) else $error("grant");
	req_hold_a: assert property (mem_req.req && !mem_rsp.ack |=>
		$stable(mem_req)) else $error("mem hold");
	fetch_done_a: assert property (mem_req.req && !mem_req.we && mem_rsp.ack
		|=> grant_ready && !mem_req.req) else $error("fetch end");
endmodule

bind dcsb_top dcsb_top_sva sva (.*);

// [tb/dcsb_mem_model.sv]
`timescale 1ns/1ps
// System memory slots with a set wait before each ack
module dcsb_mem_model (
	input  wire logic                    clock,
	input  wire dcsb_pkg::dcsb_mem_req_t mem_req,
	input  wire logic [3:0]              lat,
	output dcsb_pkg::dcsb_mem_rsp_t      mem_rsp
);
	logic [15:0] mem [16];
	int          n = 0;
	// Each slot starts with a count built from its index
	initial begin
		mem_rsp = '0;
		for (int i = 0; i < 16; i++) mem[i] = {12'h100, 4'(i)};
	end
	// Idle read data toggles so nothing stale looks valid
	always @(posedge clock) begin
		mem_rsp.ack <= 1'b0;
		mem_rsp.rdata <= ~mem_rsp.rdata;
		if (mem_req.req && !mem_rsp.ack) begin
			n <= n + 1;
			if (n >= lat) begin
				n <= 0;
				mem_rsp.ack <= 1'b1;
				if (mem_req.we) mem[mem_req.addr[7:4]] <= mem_req.wdata;
				else mem_rsp.rdata <= mem[mem_req.addr[7:4]];
			end
		end
	end
endmodule

// [tb/dcsb_top_tb.sv]
`timescale 1ns/1ps
module dcsb_top_tb;
	logic                     clock = 0, rstn = 0, beat_done = 0, rd_q = 0;
	logic                     grant_ready, irq;
	logic [3:0]               lat = 0;
	logic [31:0]              rdata, dslot, db, wb, rnd = 67950;
	logic [15:0]              c2, c4;
	logic [31:0]              q [$];
	int                       errors = 0, compares = 0;
	dcsb_pkg::dcsb_bus_req_t  bus = '0;
	dcsb_pkg::dcsb_chan_evt_t evt;
	dcsb_pkg::dcsb_grant_t    grant = '0;
	dcsb_pkg::dcsb_mem_req_t  mreq;
	dcsb_pkg::dcsb_mem_rsp_t  mrsp;
	dcsb_top dut (.clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata),
		.evt(evt), .grant(grant), .beat_done(beat_done),
		.grant_ready(grant_ready), .mem_req(mreq), .mem_rsp(mrsp),
		.desc_slot_addr(dslot), .channel_activity_flags(),
		.pending_channel_flags(), .irq(irq));
	dcsb_mem_model mem (.clock(clock), .mem_req(mreq), .lat(lat),
		.mem_rsp(mrsp));
	////////////////////////////////////////
	function automatic logic [31:0] nx(input logic [31:0] x);
		return (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0);
	endfunction
	function automatic dcsb_pkg::dcsb_chan_evt_t mk(
		input logic [5:0] s, t, b, n, r, x);
		return '{s, t, b, n, r, x, 12'h00c};
	endfunction
	task automatic cmp(input logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		@(posedge clock);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
	endtask
	task automatic ev(input dcsb_pkg::dcsb_chan_evt_t e);
		@(posedge clock);
		evt <= e;
		@(posedge clock);
		evt <= mk(0, 0, 0, 6'h3f, 0, 0);
	endtask
	task automatic gr(input logic [4:0] c);
		@(posedge clock);
		grant <= '{1'b1, c};
		@(posedge clock);
		grant.valid <= 1'b0;
	endtask
	task automatic wt;
		@(negedge clock);
		for (int k = 0; k < 60 && grant_ready !== 1'b1; k++) @(negedge clock);
	endtask
	task automatic stop_test;
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////
	// Clock, read data monitor and watchdog
	initial forever #4 clock = ~clock;
	always @(posedge clock) rd_q <= bus.rd;
	always @(negedge clock) if (rd_q) cmp(rdata, q.pop_front());
	initial begin
		#40000;
		errors++;
		stop_test();
	end
	// Main sequence
	initial begin
		evt = mk(0, 0, 0, 6'h3f, 0, 0);
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		for (int i = 0; i < 5; i++) rd(8'h28 + 8'(4 * i), 32'h0);
		rnd = nx(nx(rnd));
		db = rnd & ~32'hf;
		rnd = nx(rnd);
		wb = rnd & ~32'hf;
		wr(8'h34, db);
		wr(8'h38, wb);
		wr(8'h3c, '1);
		rd(8'h38, wb);
		rd(8'h3c, 32'h0);
		rnd = nx(rnd);
		ev(mk(rnd[5:0], 0, 0, 6'h3f, rnd[5:0], 0));
		rd(8'h28, {26'h0, rnd[5:0]});
		rd(8'h2c, {26'h0, rnd[5:0]});
		ev(mk(0, 6'h15, 0, 6'h3f, 0, 6'h0a));
		rd(8'h28, {26'h0, rnd[5:0] & 6'h2a});
		rd(8'h2c, {26'h0, rnd[5:0] & 6'h35});
		ev(mk(0, 0, 6'h3e, 6'h3e, 0, 0));
		ev(mk(0, 0, 0, 6'h3f, 6'h02, 0));
		gr(5'd2);
		wt();
		c2 = {12'h100, wb[7:4] + 4'd2};
		rd(8'h30, {c2, 8'h82, 8'h08});
		@(posedge clock);
		beat_done <= 1'b1;
		repeat (3) @(posedge clock);
		beat_done <= 1'b0;
		lat <= 4'd3;
		gr(5'd4);
		gr(5'd5);
		wt();
		c4 = {12'h100, wb[7:4] + 4'd4};
		rd(8'h30, {c4, 8'h84, 8'h08});
		cmp(dslot, db + 32'h40);
		lat <= 4'd0;
		gr(5'd2);
		wt();
		rd(8'h30, {c2 - 16'd3, 8'h82, 8'h08});
		rd(8'h60, 32'h7);
		cmp(irq, 32'h0);
		wr(8'h64, 32'h4);
		@(negedge clock) cmp(irq, 32'h1);
		wr(8'h60, 32'h4);
		@(negedge clock) cmp(irq, 32'h0);
		stop_test();
	end
endmodule
